// File: common/reset_pkg.sv
// Purpose: Shared constants and types for the reset source controller.
// Assumes: 100 MHz system clock, APB register access with 32-bit data.
// Notes: All offsets are byte addresses of aligned words.
package reset_pkg;
    localparam int CLK_MHZ = 100;
    // Release delays, in microseconds.
    localparam int WDOG_RELEASE_US = 320;
    localparam int SOFT_RELEASE_US = 320;
    localparam int SOFT_MAX_US = 960;
    localparam int PORHOLD_US = 1000;
    localparam int MONSTAB_US = 100;
    localparam int WDOG_RELEASE_CYC = WDOG_RELEASE_US * CLK_MHZ;
    localparam int SOFT_RELEASE_CYC = SOFT_RELEASE_US * CLK_MHZ;
    localparam int SOFT_MAX_CYC = SOFT_MAX_US * CLK_MHZ;
    localparam int PORHOLD_CYC = PORHOLD_US * CLK_MHZ;
    localparam int MONSTAB_CYC = MONSTAB_US * CLK_MHZ;
    localparam int DSBY_WAIT_CYC = 35;
    localparam int CNT_W = 20;

    // Register byte offsets.
    localparam logic [7:0] OFF_STATUS0 = 8'h00;
    localparam logic [7:0] OFF_STATUS1 = 8'h04;
    localparam logic [7:0] OFF_STATUS2 = 8'h08;
    localparam logic [7:0] OFF_SOFTKEY = 8'h0c;
    localparam logic [7:0] OFF_CONFIG = 8'h10;
    localparam logic [15:0] SOFT_KEY = 16'ha501;

    // Field positions in reset_status_0.
    localparam int S0_POWERON_CAUSE_FLAG = 0;
    localparam int S0_MON0 = 1;
    localparam int S0_MON1 = 2;
    localparam int S0_MON2 = 3;
    localparam int S0_DSBY = 7;
    // Field positions in reset_status_1.
    localparam int S1_INDEPENDENT_WATCHDOG = 0;
    localparam int S1_WDT = 1;
    localparam int S1_SOFT = 2;
    localparam int S1_FAULT = 3;
    localparam int S1_MEMERR = 4;
    // Field positions in the config register.
    localparam int CF_INDEPENDENT_WATCHDOG_RST = 0;
    localparam int CF_WDT_RST = 1;

    localparam logic [7:0] STATUS0_RESET = 8'h01;
    localparam logic [2:0] MONLVL_RESET = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WDOG, ST_SOFT, ST_DSBY, ST_MON, ST_PIN
    } hold_t;

    typedef struct packed {
        logic [2:0] monBelow;
        logic [2:0] monEnable;
        logic [2:0] monResetMode;
    } monitor_t;
endpackage

// File: hdl/reset_source_controller.sv
// Purpose: Reset generation and reset-cause recording.
// Assumes: por_n is the analog power-on detector output; inputs synchronous to clk.
// Notes: Cause flags are sticky; a hardware set wins over a clearing write.
`timescale 1ns/10ps
module reset_source_controller #(
    parameter int PORHOLD_CYC = reset_pkg::PORHOLD_CYC,
    parameter int WDOG_CYC = reset_pkg::WDOG_RELEASE_CYC,
    parameter int SOFT_CYC = reset_pkg::SOFT_RELEASE_CYC,
    parameter int MONSTAB_CYC = reset_pkg::MONSTAB_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic ext_reset_pin_n,
    input wire logic indepWatchdogUnderflow,
    input wire logic windowWatchdogOverflow,
    input wire reset_pkg::monitor_t supplyMonitor,
    input wire logic [2:0] option_function_word_1,
    input wire logic optionLoad,
    input wire logic deepStandbyCancel,
    input wire logic peripheralFault,
    input wire logic memoryError,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic nmiRequest,
    output logic [2:0] monitorIrq,
    output logic internalReset_n
);
    localparam logic [reset_pkg::CNT_W-1:0] WDOG_LOAD = reset_pkg::CNT_W'(WDOG_CYC - 1);
    localparam logic [reset_pkg::CNT_W-1:0] SOFT_LOAD = reset_pkg::CNT_W'(SOFT_CYC - 1);
    localparam logic [reset_pkg::CNT_W-1:0] MON_LOAD = reset_pkg::CNT_W'(MONSTAB_CYC - 1);
    localparam logic [reset_pkg::CNT_W-1:0] DSBY_LOAD =
        reset_pkg::CNT_W'(reset_pkg::DSBY_WAIT_CYC - 1);
    localparam logic [reset_pkg::CNT_W-1:0] POR_LOAD = reset_pkg::CNT_W'(PORHOLD_CYC - 1);

    logic [7:0] resetStatus0;
    logic [7:0] resetStatus1;
    logic coldWarmStart;
    logic [1:0] resetSelect;
    logic [2:0] monEnable;
    logic [reset_pkg::CNT_W-1:0] porCount;
    logic porHold;
    logic [reset_pkg::CNT_W-1:0] holdCount;
    reset_pkg::hold_t holdState;
    logic [2:0] monReset;
    logic rawReset_n;
    logic syncStage;
    logic syncOut;
    logic apbWrite;
    logic apbRead;
    logic keyHit;
    logic iwdtReset;
    logic wdtReset;
    logic faultReset;

    // Power-on hold: asynchronous assert while the detector is low, counted release.
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            porCount <= POR_LOAD;
            porHold <= 1'b1;
        end else if (porCount != '0) begin
            porCount <= porCount - 1'b1;
        end else begin
            porHold <= 1'b0;
        end
    end

    // Bus decode. The slave answers in the access cycle with no wait states.
    assign apbWrite = psel && penable && pwrite;
    assign apbRead = psel && !pwrite;
    assign pready = 1'b1;
    assign keyHit = apbWrite && paddr == reset_pkg::OFF_SOFTKEY
        && pwdata[15:0] == reset_pkg::SOFT_KEY;
    assign iwdtReset = indepWatchdogUnderflow && resetSelect[reset_pkg::CF_INDEPENDENT_WATCHDOG_RST];
    assign wdtReset = windowWatchdogOverflow && resetSelect[reset_pkg::CF_WDT_RST];
    assign faultReset = peripheralFault || memoryError;

    // Unmapped addresses raise slverr during the access cycle.
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            case (paddr)
                reset_pkg::OFF_STATUS0, reset_pkg::OFF_STATUS1, reset_pkg::OFF_STATUS2,
                reset_pkg::OFF_SOFTKEY, reset_pkg::OFF_CONFIG: pslverr = 1'b0;
                default: pslverr = 1'b1;
            endcase
        end
    end

    // Read data is registered in the setup cycle so it is stable in the access cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (apbRead && !penable) begin
            case (paddr)
                reset_pkg::OFF_STATUS0: prdata <= {24'h0, resetStatus0};
                reset_pkg::OFF_STATUS1: prdata <= {24'h0, resetStatus1};
                reset_pkg::OFF_STATUS2: prdata <= {31'h0, coldWarmStart};
                reset_pkg::OFF_CONFIG: prdata <= {27'h0, monEnable, resetSelect};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Watchdog reset-or-NMI selection; defaults to reset after power-on.
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            resetSelect <= 2'h3;
        end else if (apbWrite && paddr == reset_pkg::OFF_CONFIG) begin
            resetSelect <= pwdata[1:0];
        end
    end

    // Monitors are only enabled from the option word, never from the bus.
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            monEnable <= reset_pkg::MONLVL_RESET;
        end else if (optionLoad) begin
            monEnable <= option_function_word_1;
        end
    end

    // A watchdog in NMI mode raises the NMI instead of a reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nmiRequest <= 1'b0;
        end else begin
            nmiRequest <= (indepWatchdogUnderflow && !resetSelect[reset_pkg::CF_INDEPENDENT_WATCHDOG_RST])
                || (windowWatchdogOverflow && !resetSelect[reset_pkg::CF_WDT_RST]);
        end
    end

    // Per-monitor reset or interrupt, with a stabilization delay before release.
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_mon
            logic [reset_pkg::CNT_W-1:0] stabCount;
            logic active;
            assign active = monEnable[g] && supplyMonitor.monEnable[g];
            always_ff @(posedge clk or negedge por_n) begin
                if (!por_n) begin
                    stabCount <= '0;
                    monReset[g] <= 1'b0;
                    monitorIrq[g] <= 1'b0;
                end else begin
                    monitorIrq[g] <= active && supplyMonitor.monBelow[g]
                        && !supplyMonitor.monResetMode[g];
                    if (active && supplyMonitor.monBelow[g]
                        && supplyMonitor.monResetMode[g]) begin
                        monReset[g] <= 1'b1;
                        stabCount <= MON_LOAD;
                    end else if (stabCount != '0) begin
                        stabCount <= stabCount - 1'b1;
                    end else begin
                        monReset[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Timed hold for watchdog, fault, software and deep-standby resets. The pin holds
    // by level and the monitors by level plus their own stabilization count; one counter
    // serves all timed sources since they cannot overlap usefully while reset is already asserted.
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            holdState <= reset_pkg::ST_IDLE;
            holdCount <= '0;
        end else begin
            case (holdState)
                reset_pkg::ST_IDLE: begin
                    if (iwdtReset || wdtReset) begin
                        holdState <= reset_pkg::ST_WDOG;
                        holdCount <= WDOG_LOAD;
                    end else if (keyHit) begin
                        holdState <= reset_pkg::ST_SOFT;
                        holdCount <= SOFT_LOAD;
                    end else if (deepStandbyCancel) begin
                        holdState <= reset_pkg::ST_DSBY;
                        holdCount <= DSBY_LOAD;
                    end else if (faultReset) begin
                        holdState <= reset_pkg::ST_WDOG;
                        holdCount <= WDOG_LOAD;
                    end
                end
                reset_pkg::ST_WDOG, reset_pkg::ST_SOFT, reset_pkg::ST_DSBY: begin
                    if (holdCount != '0) begin
                        holdCount <= holdCount - 1'b1;
                    end else begin
                        holdState <= reset_pkg::ST_IDLE;
                    end
                end
                default: holdState <= reset_pkg::ST_IDLE;
            endcase
        end
    end

    // Status 0: power-on and monitor/deep-standby causes. Power-on wins over pin.
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            resetStatus0 <= reset_pkg::STATUS0_RESET;
        end else begin
            if (!ext_reset_pin_n) begin
                resetStatus0[reset_pkg::S0_POWERON_CAUSE_FLAG] <= 1'b0;
            end
            if (monReset[0]) begin
                resetStatus0[reset_pkg::S0_MON0] <= 1'b1;
            end
            if (monReset[1]) begin
                resetStatus0[reset_pkg::S0_MON1] <= 1'b1;
            end
            if (monReset[2]) begin
                resetStatus0[reset_pkg::S0_MON2] <= 1'b1;
            end
            if (deepStandbyCancel) begin
                resetStatus0[reset_pkg::S0_DSBY] <= 1'b1;
            end else if (apbWrite && paddr == reset_pkg::OFF_STATUS0
                && !pwdata[reset_pkg::S0_DSBY]) begin
                resetStatus0[reset_pkg::S0_DSBY] <= 1'b0;
            end
        end
    end

    // Status 1: watchdog, software and fault causes; set wins over a clear write.
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            resetStatus1 <= 8'h00;
        end else begin
            if (apbWrite && paddr == reset_pkg::OFF_STATUS1) begin
                resetStatus1 <= resetStatus1 & pwdata[7:0];
            end
            if (iwdtReset || (indepWatchdogUnderflow && !iwdtReset)) begin
                resetStatus1[reset_pkg::S1_INDEPENDENT_WATCHDOG] <= 1'b1;
            end
            if (windowWatchdogOverflow) begin
                resetStatus1[reset_pkg::S1_WDT] <= 1'b1;
            end
            if (keyHit) begin
                resetStatus1[reset_pkg::S1_SOFT] <= 1'b1;
            end
            if (peripheralFault) begin
                resetStatus1[reset_pkg::S1_FAULT] <= 1'b1;
            end
            if (memoryError) begin
                resetStatus1[reset_pkg::S1_MEMERR] <= 1'b1;
            end
        end
    end

    // Cold/warm flag: power-on clears it, writing 1 sets it, writing 0 is ignored.
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            coldWarmStart <= 1'b0;
        end else if (apbWrite && paddr == reset_pkg::OFF_STATUS2 && pwdata[0]) begin
            coldWarmStart <= 1'b1;
        end
    end

    // Power-on, pin and rst_n assert at once, timed and monitor sources one edge later; the pin holds for as long as it is low.
    assign rawReset_n = !(porHold || !ext_reset_pin_n || (|monReset) || !rst_n
        || holdState != reset_pkg::ST_IDLE);

    // Release is retimed by two flops so the core leaves reset on a clean edge.
    always_ff @(posedge clk or negedge rawReset_n) begin
        if (!rawReset_n) begin
            syncStage <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            syncStage <= 1'b1;
            syncOut <= syncStage;
        end
    end

    assign internalReset_n = syncOut;
endmodule // reset_source_controller

// File: tb/reset_source_controller_sva.sv
// Purpose: Port-level timing checks for the reset source controller.
// Assumes: Parameters match the bound instance; one clock domain.
// Notes: Hold windows allow for the two-edge release synchroniser.
`timescale 1ns/10ps
module reset_source_controller_sva #(
    parameter int WDOG_CYC = 50,
    parameter int SOFT_CYC = 50
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic ext_reset_pin_n,
    input wire logic indepWatchdogUnderflow,
    input wire logic windowWatchdogOverflow,
    input wire logic deepStandbyCancel,
    input wire logic peripheralFault,
    input wire logic memoryError,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic nmiRequest,
    input wire logic internalReset_n
);
    // Lower bounds are loose because the first eight held cycles are checked apart.
    localparam int WD_LO = WDOG_CYC - 16;
    localparam int WD_HI = WDOG_CYC;
    localparam int SW_LO = SOFT_CYC - 16;
    localparam int SW_HI = SOFT_CYC;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A completed write to the key register.
    wire keyWrite = psel && penable && pwrite && (paddr == 8'h0c);
    sequence s_held;
        !internalReset_n [*8];
    endsequence
    property p_porHold; $rose(por_n) |-> s_held; endproperty
    property p_pinHold; !ext_reset_pin_n ##1 !ext_reset_pin_n |-> !internalReset_n; endproperty
    property p_nmiCause;
        $rose(nmiRequest) |-> $past(indepWatchdogUnderflow) || $past(windowWatchdogOverflow);
    endproperty
    property p_dsbyHold;
        deepStandbyCancel && internalReset_n |=> s_held ##[25:32] internalReset_n;
    endproperty
    property p_faultHold;
        (peripheralFault || memoryError) && internalReset_n
            |=> s_held ##[WD_LO:WD_HI] internalReset_n;
    endproperty
    property p_softHold;
        keyWrite && pwdata[15:0] == 16'ha501 && internalReset_n
            |=> s_held ##[SW_LO:SW_HI] internalReset_n;
    endproperty
    property p_wrongKey;
        keyWrite && pwdata[15:0] != 16'ha501 && internalReset_n |=> internalReset_n [*3];
    endproperty
    property p_syncRelease;
        $rose(internalReset_n) |-> $past(rst_n, 2) && $past(ext_reset_pin_n, 2);
    endproperty
    a_porHold: assert property (p_porHold) else $error("reset released early after power-on");
    a_pinHold: assert property (p_pinHold) else $error("reset not held while pin low");
    a_nmiCause: assert property (p_nmiCause) else $error("nmi without watchdog event");
    a_dsbyHold: assert property (p_dsbyHold) else $error("deep standby hold wrong");
    a_faultHold: assert property (p_faultHold) else $error("fault reset hold wrong");
    a_softHold: assert property (p_softHold) else $error("software reset hold wrong");
    a_wrongKey: assert property (p_wrongKey) else $error("reset on wrong key");
    a_syncRelease: assert property (p_syncRelease) else $error("release not synchronised");
endmodule // reset_source_controller_sva

bind reset_source_controller reset_source_controller_sva #(
    .WDOG_CYC(WDOG_CYC), .SOFT_CYC(SOFT_CYC)) chk_u (.clk(clk), .rst_n(rst_n), .por_n(por_n),
    .ext_reset_pin_n(ext_reset_pin_n), .indepWatchdogUnderflow(indepWatchdogUnderflow),
    .windowWatchdogOverflow(windowWatchdogOverflow), .deepStandbyCancel(deepStandbyCancel),
    .peripheralFault(peripheralFault), .memoryError(memoryError), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .nmiRequest(nmiRequest), .internalReset_n(internalReset_n));

// File: tb/test_reset_source_controller.sv
// Purpose: Self-checking bench for the reset source controller.
// Assumes: Shortened hold counts; zero-wait APB slave.
// Notes: Hold lengths are counted in clock edges until release.
`timescale 1ns/10ps
module test_reset_source_controller;
    localparam int PORHOLD = 100;
    localparam int WDOG = 50;
    localparam int SOFT = 50;
    localparam int MONSTAB = 20;
    logic clk = 1'b0;
    logic rst_n, por_n, ext_reset_pin_n, independent_watchdog, wwdt, dsby, fault, memErr, optionLoad;
    logic psel, penable, pwrite, pready, pslverr, nmiRequest, internalReset_n, err;
    logic [2:0] optWord, monitorIrq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    reset_pkg::monitor_t mon;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;

    reset_source_controller #(.PORHOLD_CYC(PORHOLD), .WDOG_CYC(WDOG), .SOFT_CYC(SOFT),
        .MONSTAB_CYC(MONSTAB)) dut_u (.clk(clk), .rst_n(rst_n), .por_n(por_n),
        .ext_reset_pin_n(ext_reset_pin_n), .indepWatchdogUnderflow(independent_watchdog),
        .windowWatchdogOverflow(wwdt), .supplyMonitor(mon), .option_function_word_1(optWord),
        .optionLoad(optionLoad), .deepStandbyCancel(dsby), .peripheralFault(fault),
        .memoryError(memErr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nmiRequest(nmiRequest), .monitorIrq(monitorIrq), .internalReset_n(internalReset_n));

    // Free-running 100 MHz clock.
    initial forever #5 clk = ~clk;

    // The whole sequence needs well under a thousand cycles, so this ceiling only catches hangs.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end

    task results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; read data and error are taken at the edge that sees pready.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        forever begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    // One-cycle event pulse: 0 independent_watchdog, 1 wwdt, 2 fault, 3 memory error, else deep standby.
    task pulse(input int src);
        @(posedge clk);
        case (src)
            0: independent_watchdog <= 1'b1;
            1: wwdt <= 1'b1;
            2: fault <= 1'b1;
            3: memErr <= 1'b1;
            default: dsby <= 1'b1;
        endcase
        @(posedge clk) {independent_watchdog, wwdt, fault, memErr, dsby} <= 5'h0;
    endtask

    // Counts edges until the internal reset is released again.
    task lowLen;
        #1;
        n = 0;
        while (internalReset_n !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    initial begin
        rst_n = 1'b0;
        por_n = 1'b0;
        ext_reset_pin_n = 1'b1;
        {independent_watchdog, wwdt, fault, memErr, dsby, optionLoad, psel, penable, pwrite} = 9'h0;
        optWord = 3'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        mon = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        lowLen;
        check("power-on hold", n >= PORHOLD && n <= PORHOLD + 4, 1);
        rdChk(8'h00, 32'h1, "status0 after power-on");
        rdChk(8'h08, 32'h0, "cold start flag");
        rdChk(8'h10, 32'h3, "config after power-on");
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h08, 32'h0);
        rdChk(8'h08, 32'h1, "warm flag after writes");
        @(posedge clk) ext_reset_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check("pin hold", internalReset_n, 0);
        @(posedge clk) ext_reset_pin_n <= 1'b1;
        lowLen;
        rdChk(8'h00, 32'h0, "power-on flag after pin");
        rdChk(8'h08, 32'h1, "warm flag kept");
        apb(1'b1, 8'h0c, 32'h1234);
        #1 check("wrong key", internalReset_n, 1);
        // Both watchdogs are idle here, so nothing needs servicing before the key.
        apb(1'b1, 8'h0c, 32'ha501);
        lowLen;
        check("soft hold", n >= SOFT && n <= SOFT + 4, 1);
        rdChk(8'h04, 32'h4, "soft flag");
        pulse(4);
        lowLen;
        check("deep standby hold", n >= 34 && n <= 38, 1);
        rdChk(8'h00, 32'h80, "deep standby flag");
        apb(1'b1, 8'h10, 32'h0);
        for (int i = 0; i < 2; i++) begin
            pulse(i);
            #1 check("nmi", nmiRequest, 1);
            check("no reset in nmi mode", internalReset_n, 1);
        end
        apb(1'b1, 8'h10, 32'h3);
        apb(1'b1, 8'h04, 32'h0);
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            lowLen;
            check("timed hold", n >= WDOG && n <= WDOG + 4, 1);
            rdChk(8'h04, 32'h1 << (i < 2 ? i : i + 1), "status1 cause");
            apb(1'b1, 8'h04, 32'h0);
        end
        rdChk(8'h00, 32'h80, "deep standby flag kept");
        @(posedge clk) mon <= '{3'h7, 3'h7, 3'h0};
        repeat (3) @(posedge clk);
        #1 check("monitors off", monitorIrq, 0);
        @(posedge clk);
        optWord <= 3'h7;
        optionLoad <= 1'b1;
        @(posedge clk) optionLoad <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check("monitor irq", monitorIrq, 3'h7);
        rdChk(8'h10, 32'h1f, "monitor enables");
        @(posedge clk) mon <= '{3'h0, 3'h7, 3'h7};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) mon.monBelow <= 3'h1 << i;
            repeat (4) @(posedge clk);
            #1 check("monitor reset", internalReset_n, 0);
            @(posedge clk) mon.monBelow <= 3'h0;
            lowLen;
            check("monitor stabilisation", n >= MONSTAB && n <= MONSTAB + 5, 1);
            rdChk(8'h00, 32'h80 | ((32'h4 << i) - 32'h2), "monitor flag");
        end
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", err, 1);
        check("unmapped data", rd, 0);
        results();
    end
endmodule // test_reset_source_controller
